/* File: verilog/asc_status_io.sv */
`timescale 1ns/10ps
`include "asc_cfg.svh"
// ****************************************************************
// analyzer status and control i/o
// ****************************************************************
module asc_status_io
  import asc_pkg::*;
#(
  parameter int unsigned DEB_CYC = `ASC_DEB_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic mode_open,
  input wire logic spanzero_open,
  input wire logic range_open,
  input wire logic sensor_open,
  input wire logic clear_button,
  output logic st_health,
  output logic st_valid,
  output logic st_cal,
  output logic st_span,
  output logic st_range,
  output logic st_sensor_co2,
  output logic relay_health,
  output logic relay_conc1,
  output logic relay_conc2,
  output logic relay_range
);
  // ****************************************************************
  // contact inputs
  // ****************************************************************
  logic [3:0] raw_in;
  logic [3:0] clean_in;
  assign raw_in = {sensor_open, range_open, spanzero_open, mode_open};

  // one filter per contact input, none on clear_button; cheap next to the risk of chatter toggling modes
  for (genvar i = 0; i < 4; i++) begin : g_deb
    asc_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
      .clk(clk),
      .arst_n(arst_n),
      .raw_in(raw_in[i]),
      .clean_out(clean_in[i])
    );
  end

  wire cal_req = clean_in[0];
  wire span_req = clean_in[1];
  wire range2_sel = clean_in[2];
  wire o2_sel = clean_in[3];

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] ctrl_reg;
  logic warn_clr;
  logic [1:0] warn_reg;
  asc_mode_e mode_reg;
  asc_mode_e mode_next;
  logic [31:0] stat_word;
  logic [31:0] warn_word;
  logic [31:0] inps_word;

  asc_wb_regs u_regs (
    .clk(clk),
    .arst_n(arst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .stat_word(stat_word),
    .warn_word(warn_word),
    .inps_word(inps_word),
    .ctrl_reg(ctrl_reg),
    .warn_clr(warn_clr)
  );

  wire fault = ctrl_reg[`ASC_CTRL_FAULT];
  wire hold_off = ctrl_reg[`ASC_CTRL_HOLD];
  wire hi_range = ctrl_reg[`ASC_CTRL_HIRANGE];
  wire diagnostic_mode = ctrl_reg[`ASC_CTRL_DIAGNOSTIC];
  wire conc1_over = ctrl_reg[`ASC_CTRL_CONC1];
  wire conc2_over = ctrl_reg[`ASC_CTRL_CONC2];
  wire auto_range = ctrl_reg[`ASC_CTRL_AUTO];
  wire warn_ext = ctrl_reg[`ASC_CTRL_WARN];

  // ****************************************************************
  // mode machine
  // ****************************************************************
  // diagnostic overrides contacts; otherwise contacts pick the mode
  always_comb begin
    mode_next = ASC_MEAS;
    case (1'b1)
      diagnostic_mode: mode_next = ASC_DIAGNOSTIC;
      cal_req: mode_next = span_req ? ASC_CAL_SPAN : ASC_CAL_ZERO;
      default: mode_next = ASC_MEAS;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) mode_reg <= ASC_MEAS;
    else mode_reg <= mode_next;
  end

  wire in_cal = (mode_reg == ASC_CAL_ZERO) || (mode_reg == ASC_CAL_SPAN);

  // latched panel warnings; a new exceedance wins over a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) warn_reg <= 2'b00;
    else warn_reg <= ((warn_clr | clear_button) ? 2'b00 : warn_reg) | {conc2_over, conc1_over};
  end

  wire warning = (|warn_reg) | warn_ext;
  wire health_ok = ~fault & ~warning & ~diagnostic_mode;
  wire range_hi_act = hi_range; // dual or auto high range

  // ****************************************************************
  // outputs (flopped)
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_health <= 1'b0;
      st_valid <= 1'b0;
      st_cal <= 1'b0;
      st_span <= 1'b0;
      st_range <= 1'b0;
      st_sensor_co2 <= 1'b0;
      relay_health <= 1'b0;
      relay_conc1 <= 1'b0;
      relay_conc2 <= 1'b0;
      relay_range <= 1'b0;
    end else begin
      st_health <= ~fault;
      st_valid <= ~fault & ~hold_off & ~in_cal & (mode_reg == ASC_MEAS);
      st_cal <= in_cal;
      st_span <= (mode_reg == ASC_CAL_SPAN);
      st_range <= range_hi_act;
      st_sensor_co2 <= in_cal & ~o2_sel;
      // energized coil = healthy; de-energized on fault or power loss
      relay_health <= health_ok;
      relay_conc1 <= conc1_over;
      relay_conc2 <= conc2_over;
      relay_range <= range_hi_act & auto_range;
    end
  end

  assign stat_word = {24'h000000, mode_reg, warning, health_ok, range2_sel, o2_sel};
  assign warn_word = {30'h0, warn_reg};
  assign inps_word = {28'h0000000, clean_in};

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_health;
    @(posedge clk) disable iff (!arst_n) fault |=> !st_health;
  endproperty
  a_health: assert property (p_health) else $error("health on under fault");

  property p_valid;
    @(posedge clk) disable iff (!arst_n) (hold_off || in_cal) |=> !st_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("valid during hold-off");

  property p_cal;
    @(posedge clk) disable iff (!arst_n) st_cal == $past(in_cal);
  endproperty
  a_cal: assert property (p_cal) else $error("cal status mismatch");

  property p_range;
    @(posedge clk) disable iff (!arst_n) $rose(hi_range) |=> st_range;
  endproperty
  a_range: assert property (p_range) else $error("range status late");

  sequence s_cal_contact;
    cal_req && !diagnostic_mode;
  endsequence
  property p_mode;
    @(posedge clk) disable iff (!arst_n) s_cal_contact |=> in_cal ##1 st_cal;
  endproperty
  a_mode: assert property (p_mode) else $error("calibration not entered");

  property p_span;
    @(posedge clk) disable iff (!arst_n)
      (cal_req && !diagnostic_mode && !span_req) |=> (mode_reg == ASC_CAL_ZERO);
  endproperty
  a_span: assert property (p_span) else $error("zero cal not started");

  property p_diagnostic;
    @(posedge clk) disable iff (!arst_n) diagnostic_mode |=> !relay_health;
  endproperty
  a_diagnostic: assert property (p_diagnostic) else $error("health relay in diagnostic");

  property p_conc;
    @(posedge clk) disable iff (!arst_n) $fell(conc1_over) |=> !relay_conc1;
  endproperty
  a_conc: assert property (p_conc) else $error("conc relay latched");

  property p_warn;
    @(posedge clk) disable iff (!arst_n)
      (warn_reg[0] && !warn_clr && !clear_button) |=> warn_reg[0];
  endproperty
  a_warn: assert property (p_warn) else $error("warning lost");

  property p_auto;
    @(posedge clk) disable iff (!arst_n) (hi_range && auto_range) |=> relay_range;
  endproperty
  a_auto: assert property (p_auto) else $error("range relay off");

  property p_auto_off;
    @(posedge clk) disable iff (!arst_n) !auto_range |=> !relay_range;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("range relay without auto");

  property p_health_on;
    @(posedge clk) disable iff (!arst_n) !fault |=> st_health;
  endproperty
  a_health_on: assert property (p_health_on) else $error("health off without fault");

  property p_valid_on;
    @(posedge clk) disable iff (!arst_n)
      (!fault && !hold_off && (mode_reg == ASC_MEAS)) |=> st_valid;
  endproperty
  a_valid_on: assert property (p_valid_on) else $error("valid off in clean measure");

  property p_range_off;
    @(posedge clk) disable iff (!arst_n) !hi_range |=> !st_range;
  endproperty
  a_range_off: assert property (p_range_off) else $error("range status in low range");

  property p_measure;
    @(posedge clk) disable iff (!arst_n)
      (!cal_req && !diagnostic_mode) |=> (mode_reg == ASC_MEAS);
  endproperty
  a_measure: assert property (p_measure) else $error("measure not entered");

  sequence s_span_mode;
    mode_reg == ASC_CAL_SPAN;
  endsequence
  property p_span_start;
    @(posedge clk) disable iff (!arst_n)
      (cal_req && !diagnostic_mode && span_req) |=> s_span_mode ##1 st_span;
  endproperty
  a_span_start: assert property (p_span_start) else $error("span cal not started");

  property p_sensor_co2;
    @(posedge clk) disable iff (!arst_n) (in_cal && !o2_sel) |=> st_sensor_co2;
  endproperty
  a_sensor_co2: assert property (p_sensor_co2) else $error("co2 sensor not selected");

  property p_sensor_o2;
    @(posedge clk) disable iff (!arst_n) o2_sel |=> !st_sensor_co2;
  endproperty
  a_sensor_o2: assert property (p_sensor_o2) else $error("co2 shown with o2 chosen");

  property p_relay_off;
    @(posedge clk) disable iff (!arst_n) (fault || warn_ext) |=> !relay_health;
  endproperty
  a_relay_off: assert property (p_relay_off) else $error("health relay held on warning");

  // fail-safe: the coil is driven only while everything is healthy
  property p_relay_on;
    @(posedge clk) disable iff (!arst_n)
      (!fault && !warn_ext && !diagnostic_mode && (warn_reg == 2'b00)) |=> relay_health;
  endproperty
  a_relay_on: assert property (p_relay_on) else $error("health relay off while ok");

  property p_conc_on;
    @(posedge clk) disable iff (!arst_n) conc1_over |=> relay_conc1;
  endproperty
  a_conc_on: assert property (p_conc_on) else $error("conc relay one not on");

  property p_conc2;
    @(posedge clk) disable iff (!arst_n) $fell(conc2_over) |=> !relay_conc2;
  endproperty
  a_conc2: assert property (p_conc2) else $error("conc relay two latched");

  // cycles the raw mode contact has held one level; saturates so it never wraps
  logic raw_last_reg;
  logic [`ASC_DEB_W-1:0] raw_hold_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      raw_last_reg <= 1'b1;
      raw_hold_reg <= '0;
    end else begin
      raw_last_reg <= raw_in[0];
      if (raw_in[0] != raw_last_reg) begin
        raw_hold_reg <= '0;
      end else if (!(&raw_hold_reg)) begin
        raw_hold_reg <= raw_hold_reg + `ASC_DEB_W'(1);
      end
    end
  end

  // a new clean level needs the raw level steady for the whole settle time
  property p_settle;
    @(posedge clk) disable iff (!arst_n)
      $changed(clean_in[0]) |-> ($past(raw_hold_reg, 2) >= DEB_CYC - 1);
  endproperty
  a_settle: assert property (p_settle) else $error("contact taken before settling");
endmodule : asc_status_io

/* File: verilog/asc_cfg.svh */
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH
// register byte offsets
`define ASC_OFF_CTRL 8'h00
`define ASC_OFF_STAT 8'h04
`define ASC_OFF_WARN 8'h08
`define ASC_OFF_INPS 8'h0c
// control register fields
`define ASC_CTRL_FAULT 0
`define ASC_CTRL_HOLD 1
`define ASC_CTRL_HIRANGE 2
`define ASC_CTRL_DIAGNOSTIC 3
`define ASC_CTRL_CONC1 4
`define ASC_CTRL_CONC2 5
`define ASC_CTRL_AUTO 6
`define ASC_CTRL_WARN 7
`define ASC_CTRL_RST 8'h00
// debounce: 10 ms settle time, counted at 25 MHz
`define ASC_DEB_MS 10
`define ASC_CLK_KHZ 25000
`define ASC_DEB_CYC (`ASC_DEB_MS * `ASC_CLK_KHZ)
`define ASC_DEB_W 18
// unmapped read value
`define ASC_RD_ZERO 32'h0000_0000
`endif

/* File: verilog/asc_pkg.sv */
package asc_pkg;
  typedef enum logic [3:0] {
    ASC_MEAS = 4'h1,
    ASC_CAL_ZERO = 4'h2,
    ASC_CAL_SPAN = 4'h4,
    ASC_DIAGNOSTIC = 4'h8
  } asc_mode_e;
  typedef logic [31:0] asc_word_t;
endpackage : asc_pkg

/* File: verilog/asc_debounce.sv */
`timescale 1ns/10ps
`include "asc_cfg.svh"
// two-flop synchroniser and settle-time filter for one contact input
module asc_debounce #(
  parameter int unsigned DEB_CYC = `ASC_DEB_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic raw_in,
  output logic clean_out
);
  logic sync1_reg;
  logic sync2_reg;
  logic [`ASC_DEB_W-1:0] cnt_reg;
  wire differs = (sync2_reg != clean_out);
  wire settled = (cnt_reg >= `ASC_DEB_W'(DEB_CYC - 1));

  // first flop feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // output follows only after the input has held the new level long enough
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      clean_out <= 1'b1;
    end else if (!differs) begin
      cnt_reg <= '0;
    end else if (settled) begin
      cnt_reg <= '0;
      clean_out <= sync2_reg;
    end else begin
      cnt_reg <= cnt_reg + `ASC_DEB_W'(1);
    end
  end
endmodule : asc_debounce

/* File: verilog/asc_wb_regs.sv */
`timescale 1ns/10ps
`include "asc_cfg.svh"
// classic wishbone slave: one-cycle ack, control write, status reads
module asc_wb_regs
  import asc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] stat_word,
  input wire logic [31:0] warn_word,
  input wire logic [31:0] inps_word,
  output logic [7:0] ctrl_reg,
  output logic warn_clr
);
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_ctrl = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `ASC_OFF_CTRL);
  wire wr_warn = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `ASC_OFF_WARN);
  asc_word_t rd_mux;
  assign rd_mux = (wb_adr_i == `ASC_OFF_CTRL) ? {24'h000000, ctrl_reg} :
                  (wb_adr_i == `ASC_OFF_STAT) ? stat_word :
                  (wb_adr_i == `ASC_OFF_WARN) ? warn_word :
                  (wb_adr_i == `ASC_OFF_INPS) ? inps_word : `ASC_RD_ZERO;
  // clear pulse for latched warnings on any low-lane write to the warning register, whatever the data
  assign warn_clr = wr_warn;

  // unmapped addresses still ack, reading zero, writes dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      ctrl_reg <= `ASC_CTRL_RST;
    end else begin
      wb_ack_o <= req;
      if (req) wb_dat_o <= rd_mux;
      if (wr_ctrl) ctrl_reg <= wb_dat_i[7:0];
    end
  end
endmodule : asc_wb_regs

/* File: sim/asc_panel.sv */
`timescale 1ns/10ps
// ****************************************************************
// remote contact panel model
// ****************************************************************
module asc_panel (
  input wire logic clk,
  input wire logic [3:0] want_open,
  output logic mode_open,
  output logic spanzero_open,
  output logic range_open,
  output logic sensor_open
);
  logic [3:0] last_reg = 4'hf;
  logic [1:0] bnc_reg = 2'h0;
  logic [3:0] pins;
  // a real switch bounces; each bounce is shorter than the settle time
  always_ff @(posedge clk) begin
    if (want_open != last_reg) begin
      bnc_reg <= 2'h3;
    end else if (bnc_reg != 2'h0) begin
      bnc_reg <= bnc_reg - 2'h1;
    end
    last_reg <= want_open;
  end
  // odd bounce counts show the inverse of the new level on all four lines, so the lines chatter
  assign pins = bnc_reg[0] ? ~last_reg : last_reg;
  assign {sensor_open, range_open, spanzero_open, mode_open} = pins;
endmodule : asc_panel

/* File: sim/asc_status_io_tb.sv */
`timescale 1ns/10ps
`include "asc_cfg.svh"
module asc_status_io_tb
  import asc_pkg::*;
;
  logic clk, arst_n, cyc, stb, we, ack, clr;
  logic [7:0] adr;
  logic [3:0] sel, want;
  logic [31:0] wdat, rdat;
  asc_word_t rd;
  logic mo, so, ro, se, sh, sv, sc, ss, sr, sco, rh, r1, r2, rr;
  int fails, n_compared;
  // table of control words and the outputs they must give in measure mode
  logic [7:0] t_c [9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h44, 8'h08, 8'h80, 8'h10, 8'h20};
  logic [6:0] t_e [9] = '{7'h68, 7'h00, 7'h48, 7'h78, 7'h79, 7'h40, 7'h00, 7'h04, 7'h02};
  logic [6:0] t_m [9] = '{7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h08, 7'h0e, 7'h0e};
  // small debounce count keeps the run short
  asc_status_io #(.DEB_CYC(4)) u_dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .mode_open(mo), .spanzero_open(so), .range_open(ro),
    .sensor_open(se), .clear_button(clr), .st_health(sh), .st_valid(sv), .st_cal(sc),
    .st_span(ss), .st_range(sr), .st_sensor_co2(sco), .relay_health(rh),
    .relay_conc1(r1), .relay_conc2(r2), .relay_range(rr));
  asc_panel u_panel (.clk(clk), .want_open(want), .mode_open(mo), .spanzero_open(so),
    .range_open(ro), .sensor_open(se));
  task print_verdict;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; request held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = rdat;
    if (ack !== 1'b1) begin
      fails++;
      $display("BAD %0t no ack", $time);
      disable run_all;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task ck_out(input logic [6:0] e, input logic [6:0] m);
    chk({25'h0, {sh, sv, sr, rh, r1, r2, rr} & m}, {25'h0, e & m});
  endtask : ck_out
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {arst_n, cyc, stb, we, clr} = 5'h0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    want = 4'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    begin : run_all
    repeat (24) @(posedge clk);
    ck_out(7'h68, 7'h7f);
    wb(1'b0, `ASC_OFF_STAT, 32'h0, 4'hf);
    chk(rd, 32'h14);
    chk({31'h0, sc}, 32'h0);
    $display("test measure done");
    // every contact combination in calibration mode
    for (int i = 0; i < 8; i++) begin
      want <= {i[2:0], 1'b1};
      repeat (24) @(posedge clk);
      wb(1'b0, `ASC_OFF_INPS, 32'h0, 4'hf);
      chk(rd, {28'h0, i[2:0], 1'b1});
      wb(1'b0, `ASC_OFF_STAT, 32'h0, 4'hf);
      chk(rd, {24'h0, i[0] ? 4'h4 : 4'h2, 2'b01, i[1], i[2]});
      chk({28'h0, sc, ss, sco, sv}, {28'h0, 1'b1, i[0], ~i[2], 1'b0});
    end
    want <= 4'h0;
    repeat (24) @(posedge clk);
    $display("test calibration done");
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, `ASC_OFF_CTRL, {24'h0, t_c[i]}, 4'h1);
      repeat (4) @(posedge clk);
      ck_out(t_e[i], t_m[i]);
    end
    $display("test control done");
    // relays drop at once while the panel warning stays latched
    wb(1'b1, `ASC_OFF_CTRL, 32'h0, 4'h1);
    repeat (4) @(posedge clk);
    ck_out(7'h00, 7'h06);
    wb(1'b0, `ASC_OFF_WARN, 32'h0, 4'hf);
    chk(rd, 32'h3);
    clr <= 1'b1;
    repeat (2) @(posedge clk);
    clr <= 1'b0;
    wb(1'b0, `ASC_OFF_WARN, 32'h0, 4'hf);
    chk(rd, 32'h0);
    wb(1'b1, `ASC_OFF_CTRL, 32'h10, 4'h1);
    wb(1'b1, `ASC_OFF_CTRL, 32'h0, 4'h1);
    wb(1'b0, `ASC_OFF_WARN, 32'h0, 4'hf);
    chk(rd, 32'h1);
    wb(1'b1, `ASC_OFF_WARN, 32'h0, 4'h1);
    wb(1'b0, `ASC_OFF_WARN, 32'h0, 4'hf);
    chk(rd, 32'h0);
    $display("test warning done");
    // refused writes: no low byte lane, and an unmapped place
    wb(1'b1, `ASC_OFF_CTRL, 32'h1, 4'he);
    wb(1'b1, 8'h10, 32'hff, 4'hf);
    wb(1'b0, 8'h10, 32'h0, 4'hf);
    chk(rd, 32'h0);
    wb(1'b0, `ASC_OFF_CTRL, 32'h0, 4'hf);
    chk(rd, 32'h0);
    $display("test refusal done");
    end : run_all
    print_verdict();
  end
endmodule : asc_status_io_tb
